// *** pkg/pfm_pkg.sv ***
// package for the pin function multiplexer: register addresses, bit positions, codes
// assumes an 8-bit controller-side register port with 16-bit addresses
package pfm_pkg;
  // ==========================================================
  // register addresses and reset values
  localparam logic [15:0] PIN_SELECT_TWO_ADDR   = 16'h7f40;
  localparam logic [15:0] PIN_SELECT_THREE_ADDR = 16'h7f30;
  localparam logic [7:0]  PIN_SELECT_RESET      = 8'h00;
  // ==========================================================
  // pin_select_two fields
  localparam int GP10_SEL_HI    = 7;
  localparam int GP10_SEL_LO    = 6;
  localparam int GP6_SEL_HI     = 5;
  localparam int GP6_SEL_LO     = 4;
  localparam int OUTPUT_PIN_11_PWM_SEL  = 3;
  localparam int DMA3_SEL       = 2;
  localparam int DMA2_REQ_SEL   = 1;
  localparam int EXTRA_SCAN_SEL = 0;
  // ==========================================================
  // pin_select_three fields
  localparam int GP7_BUFFER_SEL    = 7;
  localparam int KBD_RESET_ALT_SEL = 6;
  localparam int OUTPUT_PIN_0_BUFFER_SEL   = 5;
  localparam int SECOND_BUS_SEL    = 4;
  localparam int FLASH_CS_SEL      = 3;
  localparam int SMI_ROUTE_SEL     = 2;
  localparam int DMA2_ACK_SEL      = 1;
  // ==========================================================
  // two-bit pin select codes
  typedef enum logic [1:0] {
    PFM_SEL_GPIO     = 2'h0,
    PFM_SEL_INFRARED = 2'h1,
    PFM_SEL_IR_RX    = 2'h2,
    PFM_SEL_RESERVED = 2'h3
  } pfm_sel_t;
endpackage

// *** design/pfm_mux.sv ***
// pin function multiplexer: two select registers and the pin routing they steer
// assumes registers reached by the controller's byte port; pad logic resolves enables
`timescale 1ns/1ps
module pfm_mux (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_gate_a20_sel,
  input  wire logic        i_drive1_sel,
  input  wire logic        i_smi_mask_reg,
  input  wire logic        i_gp18_dir,
  // general pin 10 and 6
  input  wire logic        i_gp10_out,
  input  wire logic        i_gp10_oe_b,
  input  wire logic        i_gp6_out,
  input  wire logic        i_gp6_oe_b,
  input  wire logic        i_infrared_mode_out,
  output logic             o_infrared_rx_third,
  input  wire logic        i_general_pin_10,
  output logic             o_general_pin_10,
  output logic             o_general_pin_10_oe_b,
  input  wire logic        i_general_pin_6,
  output logic             o_general_pin_6,
  output logic             o_general_pin_6_oe_b,
  // output pins
  input  wire logic [11:0] i_out_latch,
  input  wire logic        i_pulse_width_out_1,
  input  wire logic        i_dma_request_ch3,
  input  wire logic        i_dma_request_ch2,
  input  wire logic        i_cpu_reset,
  input  wire logic        i_keyboard_reset_out,
  input  wire logic        i_drive_select_1_n,
  input  wire logic        i_motor_on_1_n,
  input  wire logic        i_system_mgmt_int_n,
  output logic             o_output_pin_11,
  output logic             o_output_pin_9,
  output logic             o_output_pin_8,
  output logic             o_output_pin_7,
  output logic             o_output_pin_7_oe_b,
  output logic             o_output_pin_6,
  output logic             o_output_pin_5,
  output logic             o_output_pin_0,
  output logic             o_output_pin_0_oe_b,
  output logic             o_sirq_slot3_smi,
  // dma acknowledges
  input  wire logic        i_general_pin_19,
  input  wire logic        i_gp19_out,
  input  wire logic        i_gp19_oe_b,
  output logic             o_general_pin_19,
  output logic             o_general_pin_19_oe_b,
  output logic             o_dma_ack_ch3_n,
  input  wire logic        i_general_pin_18,
  input  wire logic        i_gp18_out,
  output logic             o_general_pin_18,
  output logic             o_general_pin_18_oe_b,
  output logic             o_dma_ack_ch2_n,
  output logic             o_gp18_in,
  // scan lines
  input  wire logic [15:12] i_scan_out,
  output logic             o_scan_out_12,
  output logic             o_scan_out_13,
  output logic             o_scan_out_13_oe_b,
  input  wire logic        i_scan_out_13,
  // general pins 4, 5, 7
  input  wire logic [1:0]  i_gp45_out,
  input  wire logic [1:0]  i_gp45_oe_b,
  output logic      [1:0]  o_general_pin_4_5,
  output logic      [1:0]  o_general_pin_4_5_oe_b,
  input  wire logic        i_gp7_out,
  input  wire logic        i_gp7_oe_b,
  output logic             o_general_pin_7,
  output logic             o_general_pin_7_oe_b,
  // second two-wire bus on general pins 11 (data) and 12 (clock)
  input  wire logic [1:0]  i_gp1112_out,
  input  wire logic [1:0]  i_gp1112_oe_b,
  input  wire logic [1:0]  i_bus2_drive_low,
  input  wire logic [1:0]  i_general_pin_11_12,
  output logic      [1:0]  o_general_pin_11_12,
  output logic      [1:0]  o_general_pin_11_12_oe_b,
  output logic      [1:0]  o_bus2_in,
  // flash chip select / general pin 0
  input  wire logic        i_flash_chip_select_n,
  input  wire logic        i_gp0_out,
  input  wire logic        i_gp0_oe_b,
  output logic             o_flash_pin,
  output logic             o_flash_pin_oe_b,
  // general pin 17
  input  wire logic        i_address_line_20_gate,
  input  wire logic        i_gp17_out,
  input  wire logic        i_gp17_oe_b,
  output logic             o_general_pin_17,
  output logic             o_general_pin_17_oe_b
);

  // ==========================================================
  // address decode, shared by the write strobes and the read mux
  logic hit_two;
  logic hit_three;

  assign hit_two   = i_reg_addr == pfm_pkg::PIN_SELECT_TWO_ADDR;
  assign hit_three = i_reg_addr == pfm_pkg::PIN_SELECT_THREE_ADDR;

  // ==========================================================
  // select registers
  logic [7:0] pin_select_two;
  logic [7:0] pin_select_three;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      pin_select_two <= pfm_pkg::PIN_SELECT_RESET;
    end else if (i_reg_wr && hit_two) begin
      pin_select_two <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      pin_select_three <= pfm_pkg::PIN_SELECT_RESET;
    end else if (i_reg_wr && hit_three) begin
      pin_select_three <= i_reg_wdata;
    end
  end

  // unmapped addresses read zero
  always_comb begin
    if (hit_two) begin
      o_reg_rdata = pin_select_two;
    end else if (hit_three) begin
      o_reg_rdata = pin_select_three;
    end else begin
      o_reg_rdata = 8'h00;
    end
  end

  // ==========================================================
  // field aliases
  pfm_pkg::pfm_sel_t gp10_sel;
  pfm_pkg::pfm_sel_t gp6_sel;
  logic              output_pin_11_pwm_sel;
  logic              dma3_sel;
  logic              dma2_req_sel;
  logic              extra_scan_sel;
  logic              gp7_buffer_sel;
  logic              kbd_reset_alt_sel;
  logic              output_pin_0_buffer_sel;
  logic              second_bus_sel;
  logic              flash_cs_sel;
  logic              smi_route_sel;
  logic              dma2_ack_sel;

  assign gp10_sel = pfm_pkg::pfm_sel_t'({pin_select_two[pfm_pkg::GP10_SEL_HI],
                                         pin_select_two[pfm_pkg::GP10_SEL_LO]});
  assign gp6_sel  = pfm_pkg::pfm_sel_t'({pin_select_two[pfm_pkg::GP6_SEL_HI],
                                         pin_select_two[pfm_pkg::GP6_SEL_LO]});
  assign output_pin_11_pwm_sel     = pin_select_two[pfm_pkg::OUTPUT_PIN_11_PWM_SEL];
  assign dma3_sel          = pin_select_two[pfm_pkg::DMA3_SEL];
  assign dma2_req_sel      = pin_select_two[pfm_pkg::DMA2_REQ_SEL];
  assign extra_scan_sel    = pin_select_two[pfm_pkg::EXTRA_SCAN_SEL];
  assign gp7_buffer_sel    = pin_select_three[pfm_pkg::GP7_BUFFER_SEL];
  assign kbd_reset_alt_sel = pin_select_three[pfm_pkg::KBD_RESET_ALT_SEL];
  assign output_pin_0_buffer_sel   = pin_select_three[pfm_pkg::OUTPUT_PIN_0_BUFFER_SEL];
  assign second_bus_sel    = pin_select_three[pfm_pkg::SECOND_BUS_SEL];
  assign flash_cs_sel      = pin_select_three[pfm_pkg::FLASH_CS_SEL];
  assign smi_route_sel     = pin_select_three[pfm_pkg::SMI_ROUTE_SEL];
  assign dma2_ack_sel      = pin_select_three[pfm_pkg::DMA2_ACK_SEL];

  // ==========================================================
  // shared two-bit select decode for general pins 10 and 6
  // returns {out, oe_b}; reserved code floats the pad as input
  function automatic logic [1:0] pfm_ir_pin(input pfm_pkg::pfm_sel_t sel,
                                            input logic gp_out,
                                            input logic gp_oe_b,
                                            input logic infrared_mode_out);
    logic [1:0] res;
    res = 2'h1;
    case (sel)
      pfm_pkg::PFM_SEL_GPIO:     res = {gp_out, gp_oe_b};
      pfm_pkg::PFM_SEL_INFRARED: res = {infrared_mode_out, 1'b0};
      default:                   res = {1'b0, 1'b1};
    endcase
    return res;
  endfunction

  assign {o_general_pin_10, o_general_pin_10_oe_b} =
    pfm_ir_pin(gp10_sel, i_gp10_out, i_gp10_oe_b, i_infrared_mode_out);
  assign {o_general_pin_6, o_general_pin_6_oe_b} =
    pfm_ir_pin(gp6_sel, i_gp6_out, i_gp6_oe_b, i_infrared_mode_out);

  // third rx input idles high when no pin provides it; pin 10 wins if both select it
  always_comb begin
    if (gp10_sel == pfm_pkg::PFM_SEL_IR_RX) begin
      o_infrared_rx_third = i_general_pin_10;
    end else if (gp6_sel == pfm_pkg::PFM_SEL_IR_RX) begin
      o_infrared_rx_third = i_general_pin_6;
    end else begin
      o_infrared_rx_third = 1'b1;
    end
  end

  // ==========================================================
  // output pins
  assign o_output_pin_11 = output_pin_11_pwm_sel ? i_pulse_width_out_1 : i_out_latch[11];
  assign o_output_pin_9  = dma3_sel ? i_dma_request_ch3 : i_out_latch[9];

  logic output_pin_8_or_reset;
  assign output_pin_8_or_reset  = i_gate_a20_sel ? i_cpu_reset : i_out_latch[8];
  assign o_output_pin_8 = dma2_req_sel ? i_dma_request_ch2 : output_pin_8_or_reset;
  assign o_scan_out_12  = dma2_ack_sel ? output_pin_8_or_reset : i_scan_out[12];

  always_comb begin
    if (i_drive1_sel) begin
      o_output_pin_5 = i_drive_select_1_n;
    end else if (kbd_reset_alt_sel) begin
      o_output_pin_5 = i_keyboard_reset_out;
    end else begin
      o_output_pin_5 = i_out_latch[5];
    end
  end
  assign o_output_pin_6 = i_drive1_sel ? i_motor_on_1_n : i_out_latch[6];

  // open-drain drives only a low and releases the pad for a one
  function automatic logic pfm_od_oe_b(input logic oe_b,
                                       input logic value,
                                       input logic open_drain);
    return oe_b | (open_drain & value);
  endfunction

  assign o_output_pin_0      = i_out_latch[0];
  // push-pull only when selected, since the pad resets as open-drain
  assign o_output_pin_0_oe_b = pfm_od_oe_b(1'b0, i_out_latch[0], !output_pin_0_buffer_sel);

  // ==========================================================
  // smi routing: mask keeps the parallel smi released (inactive high)
  always_comb begin
    if (smi_route_sel) begin
      o_output_pin_7      = 1'b0;
      o_output_pin_7_oe_b = i_smi_mask_reg | i_system_mgmt_int_n;
      o_sirq_slot3_smi    = 1'b0;
    end else begin
      o_output_pin_7      = i_out_latch[7];
      o_output_pin_7_oe_b = 1'b0;
      o_sirq_slot3_smi    = !i_smi_mask_reg;
    end
  end

  // ==========================================================
  // dma acknowledges
  assign o_general_pin_19      = i_gp19_out;
  assign o_general_pin_19_oe_b = dma3_sel ? 1'b1 : i_gp19_oe_b;
  assign o_dma_ack_ch3_n       = dma3_sel ? i_general_pin_19 : 1'b1;

  // ack select clear: gp18 is gpio, ack readable when firmware makes it an input
  assign o_general_pin_18      = i_gp18_out;
  assign o_general_pin_18_oe_b = dma2_ack_sel ? 1'b1 : !i_gp18_dir;
  assign o_dma_ack_ch2_n       = (dma2_ack_sel || !i_gp18_dir) ? i_general_pin_18 : 1'b1;
  // gpio 18 read path follows the pin that carries it
  assign o_gp18_in             = dma2_ack_sel ? i_scan_out_13 : i_general_pin_18;
  assign o_scan_out_13         = dma2_ack_sel ? i_gp18_out : i_scan_out[13];
  assign o_scan_out_13_oe_b    = dma2_ack_sel ? !i_gp18_dir : 1'b0;

  // ==========================================================
  // general pins 4, 5, 7
  assign o_general_pin_4_5     = extra_scan_sel ? i_scan_out[15:14] : i_gp45_out;
  assign o_general_pin_4_5_oe_b = extra_scan_sel ? 2'h0 : i_gp45_oe_b;

  assign o_general_pin_7       = i_gp7_out;
  // open-drain releases on a one instead of driving it
  assign o_general_pin_7_oe_b  = pfm_od_oe_b(i_gp7_oe_b, i_gp7_out, gp7_buffer_sel);

  // ==========================================================
  // second two-wire bus: open-drain, only pulls low
  assign o_general_pin_11_12      = second_bus_sel ? 2'h0 : i_gp1112_out;
  assign o_general_pin_11_12_oe_b = second_bus_sel ? ~i_bus2_drive_low : i_gp1112_oe_b;
  assign o_bus2_in                = second_bus_sel ? i_general_pin_11_12 : 2'h3;

  // ==========================================================
  // flash chip select and general pin 17
  assign o_flash_pin      = flash_cs_sel ? i_gp0_out : i_flash_chip_select_n;
  assign o_flash_pin_oe_b = flash_cs_sel ? i_gp0_oe_b : 1'b0;

  assign o_general_pin_17      = i_gate_a20_sel ? i_address_line_20_gate : i_gp17_out;
  assign o_general_pin_17_oe_b = i_gate_a20_sel ? 1'b0 : i_gp17_oe_b;

endmodule

// *** sim/pfm_checker.sv ***
// concurrent checks on the pin function multiplexer ports
// assumes the byte port is the only path that changes the select registers
`timescale 1ns/1ps
module pfm_checker (
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic [15:0] i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        i_gate_a20_sel,
  input wire logic        i_smi_mask_reg,
  input wire logic [11:0] i_out_latch,
  input wire logic        i_pulse_width_out_1,
  input wire logic        i_dma_request_ch3,
  input wire logic        i_dma_request_ch2,
  input wire logic        i_cpu_reset,
  input wire logic        i_system_mgmt_int_n,
  input wire logic        o_output_pin_11,
  input wire logic        o_output_pin_9,
  input wire logic        o_output_pin_8,
  input wire logic        o_output_pin_7,
  input wire logic        o_output_pin_7_oe_b,
  input wire logic        o_output_pin_0_oe_b,
  input wire logic        o_sirq_slot3_smi
);
  // ==========================================================
  // shadow copies of the select registers
  logic [7:0] s2;
  logic [7:0] s3;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) s2 <= 8'h00;
    else if (i_reg_wr && i_reg_addr == 16'h7f40) s2 <= i_reg_wdata;
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) s3 <= 8'h00;
    else if (i_reg_wr && i_reg_addr == 16'h7f30) s3 <= i_reg_wdata;
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  write_read_back_a: assert property ((i_reg_wr && i_reg_addr == 16'h7f30) ##1
    (i_reg_addr == 16'h7f30) |-> o_reg_rdata == $past(i_reg_wdata))
    else $error("select three read back differs from write");
  read_map_a: assert property (i_reg_addr == 16'h7f40 |-> o_reg_rdata == s2)
    else $error("select two read data wrong");
  unmapped_zero_a: assert property (i_reg_addr != 16'h7f40 && i_reg_addr != 16'h7f30
    |-> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  output_pin_11_route_a: assert property (
    o_output_pin_11 == (s2[3] ? i_pulse_width_out_1 : i_out_latch[11]))
    else $error("output_pin_11 source wrong");
  output_pin_9_route_a: assert property (
    o_output_pin_9 == (s2[2] ? i_dma_request_ch3 : i_out_latch[9]))
    else $error("output_pin_9 source wrong");
  output_pin_8_route_a: assert property (o_output_pin_8 == (s2[1] ? i_dma_request_ch2 :
    (i_gate_a20_sel ? i_cpu_reset : i_out_latch[8]))) else $error("output_pin_8 source wrong");
  output_pin_0_buffer_a: assert property (s3[5] |-> !o_output_pin_0_oe_b)
    else $error("output_pin_0 not push-pull");
  serial_smi_a: assert property (!s3[2] |-> o_sirq_slot3_smi == !i_smi_mask_reg
    && o_output_pin_7 == i_out_latch[7] && !o_output_pin_7_oe_b) else $error("serial smi wrong");
  parallel_smi_a: assert property (s3[2] |-> !o_sirq_slot3_smi && !o_output_pin_7
    && o_output_pin_7_oe_b == (i_smi_mask_reg | i_system_mgmt_int_n)) else $error("pin smi wrong");
  cover property (s3[2] && !i_smi_mask_reg && !i_system_mgmt_int_n);
  cover property (s2[2] && s2[1]);
  cover property (i_reg_addr == 16'h7f41);
endmodule
bind pfm_mux pfm_checker u_chk (.*);

// *** sim/testbench.sv ***
// self-checking bench for the pin function multiplexer
// assumes one 20 MHz clock; pin inputs wander on a shift pattern every cycle
`timescale 1ns/1ps
module testbench;
  logic i_core_clk, i_rst_b, i_reg_wr, i_gate_a20_sel, i_drive1_sel, i_smi_mask_reg, i_gp18_dir;
  logic [15:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, r2, r3;
  logic i_gp10_out, i_gp10_oe_b, i_gp6_out, i_gp6_oe_b, i_infrared_mode_out, i_general_pin_10;
  logic i_general_pin_6, i_pulse_width_out_1, i_dma_request_ch3, i_dma_request_ch2, i_cpu_reset;
  logic i_keyboard_reset_out, i_drive_select_1_n, i_motor_on_1_n, i_system_mgmt_int_n;
  logic i_general_pin_19, i_gp19_out, i_gp19_oe_b, i_general_pin_18, i_gp18_out, i_scan_out_13;
  logic i_gp7_out, i_gp7_oe_b, i_flash_chip_select_n, i_gp0_out, i_gp0_oe_b;
  logic i_address_line_20_gate, i_gp17_out, i_gp17_oe_b;
  logic [11:0] i_out_latch;
  logic [15:12] i_scan_out;
  logic [1:0] i_gp45_out, i_gp45_oe_b, i_gp1112_out, i_gp1112_oe_b, i_bus2_drive_low;
  logic [1:0] i_general_pin_11_12, o_general_pin_4_5, o_general_pin_4_5_oe_b;
  logic [1:0] o_general_pin_11_12, o_general_pin_11_12_oe_b, o_bus2_in;
  logic o_infrared_rx_third, o_general_pin_10, o_general_pin_10_oe_b, o_general_pin_6;
  logic o_general_pin_6_oe_b, o_output_pin_11, o_output_pin_9, o_output_pin_8, o_output_pin_7;
  logic o_output_pin_7_oe_b, o_output_pin_6, o_output_pin_5, o_output_pin_0, o_output_pin_0_oe_b;
  logic o_sirq_slot3_smi, o_general_pin_19, o_general_pin_19_oe_b, o_dma_ack_ch3_n;
  logic o_general_pin_18, o_general_pin_18_oe_b, o_dma_ack_ch2_n, o_gp18_in, o_scan_out_12;
  logic o_scan_out_13, o_scan_out_13_oe_b, o_general_pin_7, o_general_pin_7_oe_b;
  logic o_flash_pin, o_flash_pin_oe_b, o_general_pin_17, o_general_pin_17_oe_b;
  logic [63:0] pat = 64'h0123_4567_89ab_cdef;
  logic [60:0] drv = '0;
  int errors, n_checks;
  logic [7:0] t2 [5] = '{8'h00, 8'h5f, 8'haf, 8'he0, 8'hff};
  logic [7:0] t3 [5] = '{8'h00, 8'hfe, 8'h55, 8'haa, 8'hff};
  // ==========================================================
  // clock, pin stimulus, device
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  assign {i_gp10_out, i_gp10_oe_b, i_gp6_out, i_gp6_oe_b, i_infrared_mode_out, i_general_pin_10,
    i_general_pin_6, i_pulse_width_out_1, i_dma_request_ch3, i_dma_request_ch2, i_cpu_reset,
    i_keyboard_reset_out, i_drive_select_1_n, i_motor_on_1_n, i_system_mgmt_int_n,
    i_general_pin_19, i_gp19_out, i_gp19_oe_b, i_general_pin_18, i_gp18_out, i_scan_out_13,
    i_gp7_out, i_gp7_oe_b, i_flash_chip_select_n, i_gp0_out, i_gp0_oe_b, i_address_line_20_gate,
    i_gp17_out, i_gp17_oe_b, i_gate_a20_sel, i_drive1_sel, i_smi_mask_reg, i_gp18_dir,
    i_out_latch, i_scan_out, i_gp45_out, i_gp45_oe_b, i_gp1112_out, i_gp1112_oe_b,
    i_bus2_drive_low, i_general_pin_11_12} = drv;
  always @(posedge i_core_clk) begin
    pat <= {pat[62:0], pat[63] ^ pat[62] ^ pat[60] ^ pat[59]};
    drv <= pat[60:0];
  end
  pfm_mux u_dut (.*);
  // ==========================================================
  // tasks
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    @(negedge i_core_clk);
    chk(o_reg_rdata, e);
  endtask
  task automatic chk_pins();
    logic [1:0] c10;
    logic [1:0] c6;
    logic       rx;
    logic       o8;
    logic       p5;
    c10 = r2[7:6];
    c6 = r2[5:4];
    rx = c10 == 2'h2 ? i_general_pin_10 : c6 != 2'h2 | i_general_pin_6;
    o8 = i_gate_a20_sel ? i_cpu_reset : i_out_latch[8];
    p5 = i_drive1_sel ? i_drive_select_1_n : r3[6] ? i_keyboard_reset_out : i_out_latch[5];
    chk(o_general_pin_10_oe_b, c10 == 2'h0 ? i_gp10_oe_b : c10 != 2'h1);
    if (c10 < 2'h2) chk(o_general_pin_10, c10[0] ? i_infrared_mode_out : i_gp10_out);
    chk(o_general_pin_6_oe_b, c6 == 2'h0 ? i_gp6_oe_b : c6 != 2'h1);
    if (c6 < 2'h2) chk(o_general_pin_6, c6[0] ? i_infrared_mode_out : i_gp6_out);
    chk(o_infrared_rx_third, rx);
    chk(o_output_pin_11, r2[3] ? i_pulse_width_out_1 : i_out_latch[11]);
    chk(o_output_pin_9, r2[2] ? i_dma_request_ch3 : i_out_latch[9]);
    chk(o_dma_ack_ch3_n, !r2[2] | i_general_pin_19);
    chk(o_general_pin_19, i_gp19_out);
    chk(o_general_pin_19_oe_b, r2[2] | i_gp19_oe_b);
    chk(o_output_pin_8, r2[1] ? i_dma_request_ch2 : o8);
    chk(o_scan_out_12, r3[1] ? o8 : i_scan_out[12]);
    chk(o_general_pin_4_5, r2[0] ? i_scan_out[15:14] : i_gp45_out);
    chk(o_general_pin_4_5_oe_b, r2[0] ? 2'h0 : i_gp45_oe_b);
    chk(o_general_pin_7, i_gp7_out);
    chk(o_general_pin_7_oe_b, i_gp7_oe_b | (r3[7] & i_gp7_out));
    chk(o_output_pin_5, p5);
    chk(o_output_pin_6, i_drive1_sel ? i_motor_on_1_n : i_out_latch[6]);
    chk(o_output_pin_0, i_out_latch[0]);
    chk(o_output_pin_0_oe_b, !r3[5] & i_out_latch[0]);
    chk(o_general_pin_11_12, r3[4] ? 2'h0 : i_gp1112_out);
    chk(o_general_pin_11_12_oe_b, r3[4] ? 2'(~i_bus2_drive_low) : i_gp1112_oe_b);
    chk(o_bus2_in, r3[4] ? i_general_pin_11_12 : 2'h3);
    chk(o_flash_pin, r3[3] ? i_gp0_out : i_flash_chip_select_n);
    chk(o_flash_pin_oe_b, r3[3] & i_gp0_oe_b);
    chk(o_sirq_slot3_smi, !r3[2] & !i_smi_mask_reg);
    chk(o_output_pin_7, !r3[2] & i_out_latch[7]);
    chk(o_output_pin_7_oe_b, r3[2] & (i_smi_mask_reg | i_system_mgmt_int_n));
    chk(o_dma_ack_ch2_n, (r3[1] | !i_gp18_dir) ? i_general_pin_18 : 1'b1);
    chk(o_general_pin_18, i_gp18_out);
    chk(o_general_pin_18_oe_b, r3[1] | !i_gp18_dir);
    chk(o_gp18_in, r3[1] ? i_scan_out_13 : i_general_pin_18);
    chk(o_scan_out_13, r3[1] ? i_gp18_out : i_scan_out[13]);
    chk(o_scan_out_13_oe_b, r3[1] & !i_gp18_dir);
    chk(o_general_pin_17, i_gate_a20_sel ? i_address_line_20_gate : i_gp17_out);
    chk(o_general_pin_17_oe_b, !i_gate_a20_sel & i_gp17_oe_b);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // sequence; watchdog far above the roughly 160 cycles needed
  initial begin
    repeat (5000) @(posedge i_core_clk);
    errors++;
    stop_test();
  end
  initial begin
    {i_rst_b, i_reg_wr, i_reg_addr, i_reg_wdata, r2, r3} = '0;
    repeat (16) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i == 5) begin
        @(posedge i_core_clk);
        i_rst_b <= 1'b0;
        @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        r2 = 8'h00;
        r3 = 8'h00;
      end else begin
        r2 = t2[i];
        r3 = t3[i];
        wr(16'h7f40, r2);
        wr(16'h7f30, r3);
        wr(16'h7f41, ~r2);
      end
      rd(16'h7f40, r2);
      rd(16'h7f30, r3);
      rd(16'h7f41, 8'h00);
      repeat (16) begin
        @(negedge i_core_clk);
        chk_pins();
      end
      $display("test %0d done, mismatches %0d", i, errors);
    end
    stop_test();
  end
endmodule
